// ---- logic/gpc_pkg.sv ----
// Purpose: Shared constants for the GPIO pad configuration block
// Assumes: 8-bit special function register port from the CPU core
// Notes:   Offsets, field positions and reset values are named once here
package gpc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_PAGE_ADDRESS_HIGH = 8'ha0;  // Page byte for paged data
  localparam logic [7:0] ADDR_PAD_CONTROL       = 8'hb5;  // Pad modes and strengths
  localparam logic [7:0] ADDR_PAD_SETUP         = 8'hb6;  // Edges, clock pins, ref clock

  // ************************************************************
  // Pad control fields
  // ************************************************************
  localparam int POS_STROBE       = 7;  // Pad latch strobe
  localparam int POS_PULLUP_OFF   = 6;  // Pull-up off mode
  localparam int POS_KEY_MATRIX   = 5;  // Key matrix mode
  localparam int POS_DOUBLE_DRIVE = 4;  // Double output drive
  localparam int POS_LED_MIDTRIP  = 3;  // LED pin mid trip point
  localparam int POS_PINS_MIDTRIP = 2;  // Other pins mid trip point
  localparam int POS_LED_LEVEL    = 0;  // LED current level, two bits

  // ************************************************************
  // Pad setup fields
  // ************************************************************
  localparam int POS_IRQ1_ANY_EDGE = 7;  // Interrupt 1 any edge
  localparam int POS_IRQ0_ANY_EDGE = 6;  // Interrupt 0 any edge
  localparam int POS_CLK_PIN4_SEL  = 4;  // Clock out on pin 4
  localparam int POS_CLK_PIN6_SEL  = 5;  // Clock out on pin 6
  localparam int POS_CLK_EN        = 3;  // Clock output enable
  localparam int POS_REF_EN        = 2;  // Reference clock from pin 3

  // ************************************************************
  // Pin numbers and reset values
  // ************************************************************
  localparam int PIN_KEY_LO = 1;  // First pin of pull-up off and matrix groups
  localparam int PIN_ROFF_HI = 2;  // Last pin of pull-up off group
  localparam int PIN_REF    = 3;  // Reference clock pin, last matrix pin
  localparam int PIN_CLK_A  = 4;  // First clock output pin
  localparam int PIN_LED    = 5;  // LED current pin
  localparam int PIN_CLK_B  = 6;  // Second clock output pin

  localparam logic [7:0] RST_PAGE_ADDRESS_HIGH = 8'h00;  // Page byte reset
  localparam logic [7:0] RST_PAD_CONTROL       = 8'h0c;  // Both mid trip bits set
  localparam logic [7:0] RST_PAD_SETUP         = 8'h00;  // All off
  localparam logic       RST_PAD_LATCH         = 1'h0;   // Pad mode latches at reset

endpackage

// ---- logic/gpc_irq_if.sv ----
// Purpose: Carrier between the top and one interrupt edge detector
// Assumes: Single clock domain
// Notes:   Top drives configuration and pin, detector returns a request pulse
`timescale 1ns/100ps
interface gpc_irq_if;
  logic pin;          // Interrupt pin level, sampled by the detector
  logic any_edge;     // Trigger on both edges
  logic falling_sel;  // Polarity for single edge mode
  logic req;          // One-cycle request pulse

  modport ctrl (output pin, output any_edge, output falling_sel, input req);
  modport det  (input pin, input any_edge, input falling_sel, output req);
endinterface

// ---- logic/gpc_edge_det.sv ----
// Purpose: Edge detector for one external interrupt pin
// Assumes: Pin is synchronous to clk_i
// Notes:   One request pulse per qualifying edge
`timescale 1ns/100ps
module gpc_edge_det (
  input  wire logic clk_i,
  input  wire logic rst_i,
  gpc_irq_if.det    irq
);

  logic samp_q;  // Sampled pin
  logic prev_q;  // Previous sample
  logic req_q;   // Request pulse

  // Sample the pin in the CPU clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Start from the pin level so no false edge follows reset
      samp_q <= irq.pin;
      prev_q <= irq.pin;
    end else begin
      samp_q <= irq.pin;
      prev_q <= samp_q;
    end
  end

  // Edge qualification by mode and polarity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'h0;
    end else if (irq.any_edge) begin
      req_q <= samp_q ^ prev_q;
    end else if (irq.falling_sel) begin
      req_q <= prev_q & ~samp_q;
    end else begin
      req_q <= ~prev_q & samp_q;
    end
  end

  assign irq.req = req_q;

endmodule

// ---- logic/gpc_top.sv ----
// Purpose: GPIO pad configuration registers and pad control
// Assumes: Register port is the CPU special function register access
// Notes:   Reads answer one cycle after the read strobe
`timescale 1ns/100ps
module gpc_top #(
  parameter int NUM_PINS = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          sfr_addr_i,
  input  wire logic                sfr_wr_i,
  input  wire logic                sfr_rd_i,
  input  wire logic [7:0]          sfr_wdata_i,
  output logic      [7:0]          sfr_rdata_o,
  output logic                     sfr_hit_o,
  output logic      [7:0]          page_address_o,
  input  wire logic [NUM_PINS-1:0] port_out_i,
  input  wire logic [NUM_PINS-1:0] port_oe_i,
  input  wire logic [NUM_PINS-1:0] pad_in_i,
  output logic      [NUM_PINS-1:0] pad_out_o,
  output logic      [NUM_PINS-1:0] pad_oe_o,
  output logic      [NUM_PINS-1:0] pullup_dis_o,
  output logic                     double_drive_o,
  output logic                     led_pin_midtrip_o,
  output logic                     pins_midtrip_o,
  output logic      [1:0]          led_current_level_o,
  output logic                     led_current_on_o,
  input  wire logic                gen_clk_i,
  output logic                     clk_idle_o,
  output logic                     ref_clk_o,
  input  wire logic                ext_irq0_i,
  input  wire logic                ext_irq1_i,
  input  wire logic                ext_irq0_falling_sel_i,
  input  wire logic                ext_irq1_falling_sel_i,
  output logic                     ext_irq0_req_o,
  output logic                     ext_irq1_req_o
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (NUM_PINS < 7) begin : g_bad_pins
    $error("gpc_top needs at least seven pins");
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [7:0] page_q;      // Page byte
  logic [7:0] ctrl_q;      // Pad control as written
  logic [7:0] setup_q;     // Pad setup
  logic       roff_q;      // Pull-up off pad latch
  logic       matrix_q;    // Key matrix pad latch
  logic       strobe_q;    // Strobe delayed into pad latch timing
  logic [7:0] rdata_q;     // Read data
  logic       hit_q;       // Read hit flag
  logic       clk_run_q;   // Clock gate open
  logic       clk_out_q;   // Gated clock

  // Decode of an address against one register
  function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
    sel = (a == off);
  endfunction

  // Page byte storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_q <= gpc_pkg::RST_PAGE_ADDRESS_HIGH;
    end else if (sfr_wr_i && sel(sfr_addr_i, gpc_pkg::ADDR_PAGE_ADDRESS_HIGH)) begin
      page_q <= sfr_wdata_i;
    end
  end

  // Pad control storage; modes only reach pads through the latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= gpc_pkg::RST_PAD_CONTROL;
    end else if (sfr_wr_i && sel(sfr_addr_i, gpc_pkg::ADDR_PAD_CONTROL)) begin
      ctrl_q <= sfr_wdata_i;
    end
  end

  // Pad setup storage, reserved bits kept as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q <= gpc_pkg::RST_PAD_SETUP;
    end else if (sfr_wr_i && sel(sfr_addr_i, gpc_pkg::ADDR_PAD_SETUP)) begin
      setup_q <= sfr_wdata_i;
    end
  end

  // ************************************************************
  // Pad mode latches
  // ************************************************************
  // Latch is open while strobe is high, holds after it clears;
  // done within two clocks of the clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_q <= 1'h0;
      roff_q   <= gpc_pkg::RST_PAD_LATCH;
      matrix_q <= gpc_pkg::RST_PAD_LATCH;
    end else begin
      strobe_q <= ctrl_q[gpc_pkg::POS_STROBE];
      if (strobe_q) begin
        roff_q   <= ctrl_q[gpc_pkg::POS_PULLUP_OFF];
        matrix_q <= ctrl_q[gpc_pkg::POS_KEY_MATRIX];
      end
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  // Mode bits read back from the pad latches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'h0;
    end else if (sfr_rd_i) begin
      hit_q <= 1'h1;
      if (sel(sfr_addr_i, gpc_pkg::ADDR_PAGE_ADDRESS_HIGH)) begin
        rdata_q <= page_q;
      end else if (sel(sfr_addr_i, gpc_pkg::ADDR_PAD_CONTROL)) begin
        rdata_q <= ctrl_q;
        rdata_q[gpc_pkg::POS_PULLUP_OFF] <= roff_q;
        rdata_q[gpc_pkg::POS_KEY_MATRIX] <= matrix_q;
      end else if (sel(sfr_addr_i, gpc_pkg::ADDR_PAD_SETUP)) begin
        rdata_q <= setup_q;
      end else begin
        // Not ours: answer zero, no hit
        rdata_q <= 8'h00;
        hit_q   <= 1'h0;
      end
    end else begin
      hit_q <= 1'h0;
    end
  end

  // ************************************************************
  // Clock output gate
  // ************************************************************
  // Enable only gates the waveform; a cleared enable waits for the
  // low half of the running period, then holds zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_run_q <= 1'h0;
      clk_out_q <= 1'h0;
    end else begin
      if (setup_q[gpc_pkg::POS_CLK_EN]) begin
        clk_run_q <= 1'h1;
      end else if (!gen_clk_i) begin
        clk_run_q <= 1'h0;
      end
      clk_out_q <= (clk_run_q | setup_q[gpc_pkg::POS_CLK_EN]) & gen_clk_i;
    end
  end

  // ************************************************************
  // Pad drive
  // ************************************************************
  logic [NUM_PINS-1:0] out_d;  // Next pad output
  logic [NUM_PINS-1:0] oe_d;   // Next pad enable
  logic [NUM_PINS-1:0] pud_d;  // Next pull-up disable

  // Pad override priority: reference, clock routing, matrix, port
  always_comb begin
    out_d = port_out_i;
    oe_d  = port_oe_i;
    pud_d = '0;
    for (int i = gpc_pkg::PIN_KEY_LO; i <= gpc_pkg::PIN_REF; i++) begin
      // Matrix pins driven low without pull-ups
      if (matrix_q) begin
        out_d[i] = 1'h0;
        oe_d[i]  = 1'h1;
        pud_d[i] = 1'h1;
      end
      // Pull-up off on the first two pins
      if (roff_q && i <= gpc_pkg::PIN_ROFF_HI) begin
        pud_d[i] = 1'h1;
      end
    end
    // Clock routing depends on select bits only
    if (setup_q[gpc_pkg::POS_CLK_PIN4_SEL]) begin
      out_d[gpc_pkg::PIN_CLK_A] = clk_out_q;
      oe_d[gpc_pkg::PIN_CLK_A]  = 1'h1;
    end
    if (setup_q[gpc_pkg::POS_CLK_PIN6_SEL]) begin
      out_d[gpc_pkg::PIN_CLK_B] = clk_out_q;
      oe_d[gpc_pkg::PIN_CLK_B]  = 1'h1;
    end
    // LED pin never drives as a normal output
    out_d[gpc_pkg::PIN_LED] = 1'h0;
    oe_d[gpc_pkg::PIN_LED]  = 1'h0;
    // Reference clock pin forced to input over port setup
    if (setup_q[gpc_pkg::POS_REF_EN]) begin
      out_d[gpc_pkg::PIN_REF] = 1'h0;
      oe_d[gpc_pkg::PIN_REF]  = 1'h0;
    end
  end

  logic [NUM_PINS-1:0] out_q;  // Pad output
  logic [NUM_PINS-1:0] oe_q;   // Pad enable
  logic [NUM_PINS-1:0] pud_q;  // Pull-up disable
  logic                ref_q;  // Reference clock sample
  logic                led_q;  // LED current switch
  logic                stat_q; // Clock gate closed status

  // Registered pad controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q  <= '0;
      oe_q   <= '0;
      pud_q  <= '0;
      ref_q  <= 1'h0;
      led_q  <= 1'h0;
      stat_q <= 1'h1;
    end else begin
      out_q  <= out_d;
      oe_q   <= oe_d;
      pud_q  <= pud_d;
      ref_q  <= setup_q[gpc_pkg::POS_REF_EN] & pad_in_i[gpc_pkg::PIN_REF];
      // LED conducts only with a non-zero level
      led_q  <= port_out_i[gpc_pkg::PIN_LED] & (|ctrl_q[gpc_pkg::POS_LED_LEVEL +: 2]);
      // Idle only when neither the held gate nor the enable can pass the clock
      stat_q <= ~(clk_run_q | setup_q[gpc_pkg::POS_CLK_EN]);
    end
  end

  // ************************************************************
  // Interrupt edge detectors
  // ************************************************************
  gpc_irq_if irq0 ();
  gpc_irq_if irq1 ();

  // Edge mode and polarity per interrupt
  assign irq0.pin         = ext_irq0_i;
  assign irq0.any_edge    = setup_q[gpc_pkg::POS_IRQ0_ANY_EDGE];
  assign irq0.falling_sel = ext_irq0_falling_sel_i;
  assign irq1.pin         = ext_irq1_i;
  assign irq1.any_edge    = setup_q[gpc_pkg::POS_IRQ1_ANY_EDGE];
  assign irq1.falling_sel = ext_irq1_falling_sel_i;

  gpc_edge_det u_irq0 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .irq   (irq0.det)
  );

  gpc_edge_det u_irq1 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .irq   (irq1.det)
  );

  // ************************************************************
  // Outputs
  // ************************************************************
  assign sfr_rdata_o         = rdata_q;
  assign sfr_hit_o           = hit_q;
  assign page_address_o      = page_q;
  assign pad_out_o           = out_q;
  assign pad_oe_o            = oe_q;
  assign pullup_dis_o        = pud_q;
  assign double_drive_o      = ctrl_q[gpc_pkg::POS_DOUBLE_DRIVE];
  assign led_pin_midtrip_o   = ctrl_q[gpc_pkg::POS_LED_MIDTRIP];
  assign pins_midtrip_o      = ctrl_q[gpc_pkg::POS_PINS_MIDTRIP];
  assign led_current_level_o = ctrl_q[gpc_pkg::POS_LED_LEVEL +: 2];
  assign led_current_on_o    = led_q;
  assign clk_idle_o          = stat_q;
  assign ref_clk_o           = ref_q;
  assign ext_irq0_req_o      = irq0.req;
  assign ext_irq1_req_o      = irq1.req;

endmodule

// ---- test/gpc_pad_model.sv ----
// Purpose: Pads, buttons and clock source around the pad configuration block
// Assumes: Buttons pull a pin low; pull-ups pull an undriven pin high
// Notes:   A pin with no driver and no pull-up toggles every cycle
`timescale 1ns/100ps
module gpc_pad_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  input  wire logic [7:0] pullup_dis_i,
  input  wire logic [7:0] press_i,
  output logic      [7:0] pad_lvl_o,
  output logic            gen_clk_o
);
  logic [1:0] div_q = 2'h0;  // Divider for the generated clock
  logic       float_q = 1'b0;  // Level of a floating pin

  // Generated clock at a quarter of the CPU clock
  always_ff @(posedge clk_i) begin
    div_q   <= div_q + 2'h1;
    float_q <= ~float_q;
  end
  assign gen_clk_o = div_q[1];

  // Pin level from the driver, a pressed button or the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_i[i]) begin
        pad_lvl_o[i] = pad_out_i[i];
      end else if (press_i[i]) begin
        pad_lvl_o[i] = 1'b0;
      end else begin
        pad_lvl_o[i] = pullup_dis_i[i] ? float_q : 1'b1;
      end
    end
  end
endmodule

// ---- test/gpc_top_asserts.sv ----
// Purpose: Port-level checks of the pad configuration block
// Assumes: One clock, synchronous active-high reset
// Notes:   Keeps its own copy of the pad setup byte from observed writes
`timescale 1ns/100ps
module gpc_top_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  input wire logic [7:0] page_address_o,
  input wire logic [7:0] port_out_i,
  input wire logic [7:0] pad_in_i,
  input wire logic [7:0] pad_out_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic       double_drive_o,
  input wire logic [1:0] led_current_level_o,
  input wire logic       led_current_on_o,
  input wire logic       clk_idle_o,
  input wire logic       ref_clk_o,
  input wire logic       ext_irq0_i,
  input wire logic       ext_irq0_falling_sel_i,
  input wire logic       ext_irq0_req_o
);
  // ************************************************************
  // Shadow of the setup byte
  // ************************************************************
  logic [7:0] setup_q;  // Last value written to the setup register
  logic       mapped;   // Address hits one of the three registers
  assign mapped = sfr_addr_i inside {8'ha0, 8'hb5, 8'hb6};

  // Follows writes to the setup register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q <= 8'h00;
    end else if (sfr_wr_i && sfr_addr_i == 8'hb6) begin
      setup_q <= sfr_wdata_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_page_wr;
    sfr_wr_i && sfr_addr_i == 8'ha0;
  endsequence
  sequence s_page_rd;
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'ha0;
  endsequence

  a_hit_mapped: assert property (sfr_rd_i && mapped |=> sfr_hit_o)
    else $error("read of a mapped register without hit");
  a_unmapped_zero: assert property (sfr_rd_i && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("unmapped read not empty");
  a_page_store: assert property (s_page_wr |=> page_address_o == $past(sfr_wdata_i))
    else $error("page byte not stored");
  a_page_back: assert property (s_page_wr ##1 !sfr_wr_i ##1 s_page_rd |=>
    sfr_rdata_o == $past(sfr_wdata_i, 3))
    else $error("page byte read back wrong");
  a_ctrl_fields: assert property (sfr_wr_i && sfr_addr_i == 8'hb5 |=>
    {double_drive_o, led_current_level_o} == $past({sfr_wdata_i[4], sfr_wdata_i[1:0]}))
    else $error("drive or led level not taken from write");
  a_led_gate: assert property (led_current_on_o ==
    $past(port_out_i[5] && led_current_level_o != 2'h0) && !pad_oe_o[5])
    else $error("led current switch wrong");
  a_ref_follow: assert property (ref_clk_o == $past(setup_q[2] && pad_in_i[3]))
    else $error("reference clock does not follow pin 3");
  a_ref_input: assert property (setup_q[2] |=> !pad_oe_o[3])
    else $error("pin 3 driven while reference enabled");
  a_irq_rise: assert property ($rose(ext_irq0_i) && !setup_q[6] && !ext_irq0_falling_sel_i
    |-> ##[1:2] ext_irq0_req_o)
    else $error("rising edge gave no request");
  a_irq_any: assert property ($changed(ext_irq0_i) && setup_q[6] |-> ##[1:2] ext_irq0_req_o)
    else $error("any edge gave no request");
  a_irq_pulse: assert property (ext_irq0_req_o |=> !ext_irq0_req_o)
    else $error("request longer than one cycle");
  a_clk_hold: assert property (clk_idle_o && setup_q[4] |=> !pad_out_o[4])
    else $error("idle clock pin not low");
endmodule

bind gpc_top gpc_top_asserts gpc_top_asserts_inst (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .page_address_o, .port_out_i,
  .pad_in_i, .pad_out_o, .pad_oe_o, .double_drive_o, .led_current_level_o, .led_current_on_o,
  .clk_idle_o, .ref_clk_o, .ext_irq0_i, .ext_irq0_falling_sel_i, .ext_irq0_req_o);

// ---- test/gpio_pad_config_control_tb_top.sv ----
// Purpose: Register-driven tests of the pad configuration block
// Assumes: Reads answer one cycle after the read strobe
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module gpio_pad_config_control_tb_top;
  logic       clk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, port_out_i = 8'hff, port_oe_i = 8'h20;
  logic [7:0] press_q = 8'h00, sfr_rdata_o, page_address_o, pad_in_i, pad_out_o, pad_oe_o;
  logic [7:0] pullup_dis_o, edges, prev;
  logic       ext_irq0_i = 1'b0, ext_irq1_i = 1'b0;
  logic       ext_irq0_falling_sel_i = 1'b0, ext_irq1_falling_sel_i = 1'b0;
  logic       sfr_hit_o, double_drive_o, led_pin_midtrip_o, pins_midtrip_o, led_current_on_o;
  logic       gen_clk_i, clk_idle_o, ref_clk_o, ext_irq0_req_o, ext_irq1_req_o;
  logic [1:0] led_current_level_o;
  int         err_total = 0, cmp_count = 0, cyc = 0;

  always #20 clk_i = ~clk_i;  // 25 MHz

  gpc_top #(.NUM_PINS(8)) gpc_top_inst (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .page_address_o, .port_out_i, .port_oe_i,
    .pad_in_i, .pad_out_o, .pad_oe_o, .pullup_dis_o, .double_drive_o, .led_pin_midtrip_o,
    .pins_midtrip_o, .led_current_level_o, .led_current_on_o, .gen_clk_i, .clk_idle_o,
    .ref_clk_o, .ext_irq0_i, .ext_irq1_i, .ext_irq0_falling_sel_i, .ext_irq1_falling_sel_i,
    .ext_irq0_req_o, .ext_irq1_req_o);

  gpc_pad_model gpc_pad_model_inst (.clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pullup_dis_i(pullup_dis_o), .press_i(press_q), .pad_lvl_o(pad_in_i), .gen_clk_o(gen_clk_i));

  // ************************************************************
  // Access and compare tasks
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
    tick(1);
    sfr_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    tick(1);
    {sfr_addr_i, sfr_rd_i} = {a, 1'b1};
    tick(1);
    sfr_rd_i = 1'b0;
    check(sfr_rdata_o, exp);
    check({7'h0, sfr_hit_o}, {7'h0, hit});
  endtask

  // Strobe 0,1,0 then two clocks plus the pad register
  task automatic strobe(input logic [7:0] m);
    wr(8'hb5, m);
    wr(8'hb5, m | 8'h80);
    wr(8'hb5, m);
    tick(3);
  endtask

  // Move one interrupt pin and count requests
  task automatic irq_edge(input int n, input logic lvl, input logic exp);
    edges = 8'h00;
    if (n == 0) ext_irq0_i = lvl;
    else ext_irq1_i = lvl;
    repeat (4) begin
      tick(1);
      edges = edges + {7'h0, (n == 0) ? ext_irq0_req_o : ext_irq1_req_o};
    end
    check(edges, {7'h0, exp});
  endtask

  task automatic print_verdict();
    $display("Errors %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      print_verdict();
    end
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    tick(5);
    rst_i = 1'b0;
    rd(8'ha0, 8'h00, 1'b1);
    rd(8'hb5, 8'h0c, 1'b1);
    rd(8'hb6, 8'h00, 1'b1);
    rd(8'h55, 8'h00, 1'b0);
    wr(8'ha0, 8'ha5);
    rd(8'ha0, 8'ha5, 1'b1);
    wr(8'ha0, 8'h5a);
    check(page_address_o, 8'h5a);
    // Drive, trip points and every LED level
    for (int l = 0; l < 4; l++) begin
      wr(8'hb5, 8'h14 | l[7:0]);
      tick(2);
      check({3'h0, double_drive_o, led_pin_midtrip_o, pins_midtrip_o, led_current_level_o},
        {3'h0, 3'b101, l[1:0]});
      check({6'h0, led_current_on_o, pad_oe_o[5]}, {6'h0, l != 0, 1'b0});
    end
    port_out_i[5] = 1'b0;
    tick(2);
    check({7'h0, led_current_on_o}, 8'h00);
    // Pad mode latches
    strobe(8'h40);
    rd(8'hb5, 8'h40, 1'b1);
    check(pullup_dis_o & 8'h0e, 8'h06);
    wr(8'hb5, 8'h20);
    tick(3);
    rd(8'hb5, 8'h40, 1'b1);
    strobe(8'h20);
    rd(8'hb5, 8'h20, 1'b1);
    check(pullup_dis_o & 8'h0e, 8'h0e);
    check(pad_oe_o & 8'h0e, 8'h0e);
    check(pad_out_o & 8'h0e, 8'h00);
    wr(8'hb5, 8'he0);
    tick(3);
    rd(8'hb5, 8'he0, 1'b1);
    strobe(8'h00);
    rd(8'hb5, 8'h00, 1'b1);
    check(pullup_dis_o & 8'h0e, 8'h00);
    // Interrupt edge modes
    for (int n = 0; n < 2; n++) begin
      wr(8'hb6, 8'h00);
      irq_edge(n, 1'b1, 1'b1);
      irq_edge(n, 1'b0, 1'b0);
      if (n == 0) ext_irq0_falling_sel_i = 1'b1;
      else ext_irq1_falling_sel_i = 1'b1;
      irq_edge(n, 1'b1, 1'b0);
      irq_edge(n, 1'b0, 1'b1);
      wr(8'hb6, (n == 0) ? 8'h40 : 8'h80);
      irq_edge(n, 1'b1, 1'b1);
      irq_edge(n, 1'b0, 1'b1);
    end
    // Clock output routing and gating
    wr(8'hb6, 8'h18);
    tick(3);
    edges = 8'h00;
    repeat (12) begin
      prev = pad_out_o;
      tick(1);
      edges = edges + {7'h0, pad_out_o[4] !== prev[4]};
    end
    check({7'h0, edges > 8'h02}, 8'h01);
    check({6'h0, pad_oe_o[6], pad_oe_o[4]}, 8'h01);
    wr(8'hb6, 8'h38);
    tick(3);
    check({6'h0, pad_oe_o[6], pad_oe_o[4]}, 8'h03);
    wr(8'hb6, 8'h30);
    tick(6);
    check({3'h0, clk_idle_o, pad_oe_o[6], pad_oe_o[4], pad_out_o[6], pad_out_o[4]},
      8'h1c);
    wr(8'hb6, 8'h08);
    tick(3);
    check({6'h0, pad_oe_o[6], pad_oe_o[4]}, 8'h00);
    // Reference clock input on pin 3
    port_oe_i = 8'h28;
    wr(8'hb6, 8'h04);
    tick(3);
    check({6'h0, pad_oe_o[3], ref_clk_o}, 8'h01);
    press_q[3] = 1'b1;
    tick(2);
    check({7'h0, ref_clk_o}, 8'h00);
    press_q[3] = 1'b0;
    wr(8'hb6, 8'h00);
    tick(3);
    check({7'h0, pad_oe_o[3]}, 8'h01);
    print_verdict();
  end
endmodule
